// ==== dmx_exec.sv ====
// data-move group execution unit with four-phase instruction cycle
// Function
// - pointer load puts 14-bit literal in pointer chosen by 2-bit operand.
// - file move goes to accumulator (d=0) or file (d=1); only N, Z change.
// - 8-bit file address reaches any location in the selected 256-byte bank.
// - access bit zero addresses the fixed access bank, ignoring bank register.
// - access bit one uses bank register to choose the general-purpose bank.
// - extended set, access zero, f up to 95: indexed literal offset address.
// - short move copies byte between 12-bit addresses, no flag change.
// - short move is two words, prefixes 1100/1111, two cycles, three stalled.
// - long move copies byte anywhere in 16 Kbyte space via 14-bit fields.
// - long move is three words and cycles; first cycle has no data access.
// - long move treats accumulator as an ordinary source or destination.
// - bank load writes low six bits; upper two bits always zero.
// - literal load puts 8-bit literal in accumulator, one cycle, no flags.
// - accumulator store writes file in one cycle, accumulator and flags kept.
`timescale 1ns/1ps
module dmx_exec
  import dmx_pkg::*;
#(
  parameter logic [13:0] ACC_ADDR = ACC_ADDR_DEF
) (
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  input  wire logic [15:0]  instr_i,
  input  wire logic         instr_valid_i,
  output logic              instr_ack_o,
  input  wire logic         ext_en_i,
  input  wire logic [7:0]   mem_rdata_i,
  output dmx_mem_req_t      mem_o,
  output logic      [7:0]   acc_o,
  output logic      [7:0]   bsr_o,
  output dmx_flags_t        flags_o,
  output logic      [41:0]  ptr_o,
  output logic      [1:0]   qphase_o,
  output logic              busy_o
);
  logic [1:0]   q_reg;
  logic [15:0]  ir_reg;
  logic         word_ok_reg;
  dmx_state_t   state_reg;
  logic [7:0]   acc_reg;
  logic [7:0]   bsr_reg;
  dmx_flags_t   flags_reg;
  logic [7:0]   data_reg;
  logic [13:0]  src_reg;
  logic [13:0]  dst_reg;
  logic [1:0]   psel_reg;
  logic [5:0]   ptr_hi_reg [3];
  logic [7:0]   ptr_lo_reg [3];
  dmx_mem_req_t mem_reg;
  logic [13:0]  file_addr;
  logic         idle_ok;
  logic         op_ptr1;
  logic         op_fmove;
  logic         op_short1;
  logic         op_long1;
  logic         op_bank;
  logic         op_lit;
  logic         op_store;
  logic         ext_word;
  logic [13:0]  rd_addr;
  logic         rd_need;
  logic [13:0]  wr_addr;
  logic         wr_need;

  dmx_addr_form u_addr (
    .f_i      (ir_reg[7:0]),
    .a_i      (ir_reg[8]),
    .bsr_i    (bsr_reg),
    .ext_en_i (ext_en_i),
    .ptr2_i   ({ptr_hi_reg[2], ptr_lo_reg[2]}),
    .addr_o   (file_addr)
  );

  assign idle_ok   = word_ok_reg && (state_reg == S_IDLE);
  assign op_ptr1   = idle_ok && (ir_reg[15:6] == OP_PTR_LOAD) && (ir_reg[5:4] != 2'd3);
  assign op_fmove  = idle_ok && (ir_reg[15:10] == OP_FILE_MOVE);
  assign op_short1 = idle_ok && (ir_reg[15:12] == OP_SHORT_MOVE);
  // first word prefix 0000 0000 0110
  assign op_long1  = idle_ok && (ir_reg[15:4] == OP_LONG_MOVE);
  assign op_bank   = idle_ok && (ir_reg[15:6] == OP_BANK_LOAD);
  assign op_lit    = idle_ok && (ir_reg[15:8] == OP_LIT_ACC);
  assign op_store  = idle_ok && (ir_reg[15:9] == OP_ACC_STORE);
  assign ext_word  = word_ok_reg && (ir_reg[15:12] == OP_EXT_WORD);

  // a cycle without a fetched word is a bubble; that is the stall
  assign instr_ack_o = (q_reg == Q_WRITE) && instr_valid_i;
  assign busy_o      = (state_reg != S_IDLE);
  assign qphase_o    = q_reg;
  assign acc_o       = acc_reg;
  assign bsr_o       = bsr_reg;
  assign flags_o     = flags_reg;
  assign mem_o       = mem_reg;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      q_reg <= Q_DECODE;
    end else begin
      q_reg <= 2'(q_reg + 2'd1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ir_reg      <= 16'h0000;
      word_ok_reg <= 1'b0;
    end else if (q_reg == Q_WRITE) begin
      ir_reg      <= instr_i;
      word_ok_reg <= instr_valid_i;
    end
  end

  // read address and need, worked out during decode
  always_comb begin
    rd_addr = file_addr;
    rd_need = 1'b0;
    if (op_fmove) begin
      rd_need = 1'b1;
    end else if (op_short1) begin
      rd_addr = {2'b00, ir_reg[11:0]};
      rd_need = (rd_addr != ACC_ADDR);
    end else if ((state_reg == S_LONG2) && ext_word) begin
      rd_addr = {src_reg[13:10], ir_reg[11:2]};
      // accumulator as source needs no bus read
      rd_need = (rd_addr != ACC_ADDR);
    end
  end

  always_comb begin
    wr_addr = file_addr;
    wr_need = 1'b0;
    if (op_store || (op_fmove && ir_reg[9])) begin
      wr_need = 1'b1;
    end else if ((state_reg == S_SHORT2) && ext_word) begin
      wr_addr = {2'b00, ir_reg[11:0]};
      wr_need = (wr_addr != ACC_ADDR);
    end else if ((state_reg == S_LONG3) && ext_word) begin
      // accumulator as destination skips the bus
      wr_addr = {dst_reg[13:12], ir_reg[11:0]};
      wr_need = (wr_addr != ACC_ADDR);
    end
  end

  // strobes stand for one quarter: read in Q2, write in Q4
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mem_reg <= '0;
    end else if (q_reg == Q_DECODE) begin
      // first long-move cycle gets no strobe
      mem_reg.addr <= rd_addr;
      mem_reg.rd   <= rd_need;
      mem_reg.wr   <= 1'b0;
    end else if (q_reg == Q_PROCESS) begin
      // destination written in last quarter, no dummy read
      mem_reg.addr  <= wr_addr;
      mem_reg.rd    <= 1'b0;
      mem_reg.wr    <= wr_need;
      mem_reg.wdata <= op_store ? acc_reg : (op_fmove ? mem_rdata_i : data_reg);
    end else begin
      mem_reg.rd <= 1'b0;
      mem_reg.wr <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      data_reg <= 8'h00;
    end else if (q_reg == Q_PROCESS) begin
      if (rd_need) begin
        data_reg <= mem_rdata_i;
      end else if (op_short1 || ((state_reg == S_LONG2) && ext_word)) begin
        data_reg <= acc_reg;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_reg <= S_IDLE;
      src_reg   <= 14'h0000;
      dst_reg   <= 14'h0000;
      psel_reg  <= 2'd0;
    end else if ((q_reg == Q_WRITE) && word_ok_reg) begin
      case (state_reg)
        S_IDLE: begin
          if (op_ptr1) begin
            psel_reg  <= ir_reg[5:4];
            state_reg <= S_PTR2;
          end else if (op_short1) begin
            state_reg <= S_SHORT2;
          end else if (op_long1) begin
            src_reg   <= {ir_reg[3:0], 10'h000};
            state_reg <= S_LONG2;
          end
        end
        S_LONG2: begin
          dst_reg   <= {ir_reg[1:0], 12'h000};
          state_reg <= ext_word ? S_LONG3 : S_IDLE;
        end
        S_PTR2, S_SHORT2, S_LONG3: begin
          state_reg <= S_IDLE;
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      acc_reg   <= ACC_RST;
      flags_reg <= '0;
    end else if (q_reg == Q_WRITE) begin
      if (op_lit) begin
        acc_reg <= ir_reg[7:0];
      end else if (op_fmove) begin
        // destination bit and N, Z update
        if (!ir_reg[9]) begin
          acc_reg <= data_reg;
        end
        flags_reg.neg  <= data_reg[7];
        flags_reg.zero <= (data_reg == 8'h00);
      end else if ((state_reg == S_SHORT2 || state_reg == S_LONG3) && ext_word &&
                   (mem_reg.addr == ACC_ADDR) && !mem_reg.wr) begin
        acc_reg <= data_reg;
      end
    end
  end

  // upper two bank bits always loaded with zero
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      bsr_reg <= BSR_RST;
    end else if ((q_reg == Q_WRITE) && op_bank) begin
      bsr_reg <= {2'b00, ir_reg[5:0]};
    end
  end

  for (genvar p = 0; p < 3; p++) begin : g_ptr
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        ptr_hi_reg[p] <= 6'h00;
        ptr_lo_reg[p] <= 8'h00;
      end else if (q_reg == Q_WRITE) begin
        // high part first cycle, low byte second
        if (op_ptr1 && (ir_reg[5:4] == 2'(p))) begin
          ptr_hi_reg[p] <= {ir_reg[3:0], 2'b00};
        end else if ((state_reg == S_PTR2) && ext_word && (psel_reg == 2'(p))) begin
          ptr_hi_reg[p][1:0] <= ir_reg[9:8];
          ptr_lo_reg[p]      <= ir_reg[7:0];
        end
      end
    end
    assign ptr_o[14*p +: 14] = {ptr_hi_reg[p], ptr_lo_reg[p]};
  end

  a_lit_load: assert property (@(posedge clk_i) disable iff (srst_i)
    (q_reg == Q_WRITE && op_lit) |=> (acc_reg == $past(ir_reg[7:0])) && $stable(flags_reg))
    else $error("literal load missed accumulator");
  a_bank_upper: assert property (@(posedge clk_i) disable iff (srst_i)
    bsr_reg[7:6] == 2'b00)
    else $error("bank register upper bits set");
  a_store_data: assert property (@(posedge clk_i) disable iff (srst_i)
    (q_reg == Q_PROCESS && op_store) |=> mem_reg.wr && (mem_reg.wdata == acc_reg)
    ##1 $stable(acc_reg) && $stable(flags_reg))
    else $error("store wrote wrong data");
  a_write_phase: assert property (@(posedge clk_i) disable iff (srst_i)
    mem_reg.wr |-> (q_reg == Q_WRITE) && !mem_reg.rd)
    else $error("write outside last quarter");
  a_short_noread: assert property (@(posedge clk_i) disable iff (srst_i)
    (state_reg == S_SHORT2) |-> !mem_reg.rd)
    else $error("dummy read in short move");
  a_long_quiet: assert property (@(posedge clk_i) disable iff (srst_i)
    (q_reg == Q_DECODE && op_long1) |=> !mem_reg.rd ##2 !mem_reg.wr)
    else $error("long move first cycle touched memory");
  a_fmove_dest: assert property (@(posedge clk_i) disable iff (srst_i)
    (q_reg == Q_WRITE && op_fmove && !ir_reg[9]) |=>
    (acc_reg == $past(data_reg)) && (flags_reg.zero == ($past(data_reg) == 8'h00)))
    else $error("file move to accumulator wrong");
  a_short_flags: assert property (@(posedge clk_i) disable iff (srst_i)
    (state_reg == S_SHORT2) |=> $stable(flags_reg))
    else $error("short move changed flags");
  a_ptr_low: assert property (@(posedge clk_i) disable iff (srst_i)
    (q_reg == Q_WRITE && state_reg == S_PTR2 && ext_word && psel_reg == 2'd2) |=>
    (ptr_lo_reg[2] == $past(ir_reg[7:0])))
    else $error("pointer low byte not loaded");
  c_short_move: cover property (@(posedge clk_i) disable iff (srst_i)
    state_reg == S_SHORT2 ##4 state_reg == S_IDLE);
  c_short_stall: cover property (@(posedge clk_i) disable iff (srst_i)
    state_reg == S_SHORT2 && q_reg == Q_DECODE && !word_ok_reg);
  c_long_move: cover property (@(posedge clk_i) disable iff (srst_i)
    state_reg == S_LONG3 && mem_reg.wr);
  c_ptr_load: cover property (@(posedge clk_i) disable iff (srst_i)
    state_reg == S_PTR2 && q_reg == Q_WRITE && ext_word);
endmodule

// ==== dmx_pkg.sv ====
// package and data address former for the data-move execution unit
package dmx_pkg;
  localparam logic [1:0]  Q_DECODE      = 2'd0;
  localparam logic [1:0]  Q_READ        = 2'd1;
  localparam logic [1:0]  Q_PROCESS     = 2'd2;
  localparam logic [1:0]  Q_WRITE       = 2'd3;
  localparam logic [9:0]  OP_PTR_LOAD   = 10'h3b8;
  localparam logic [5:0]  OP_FILE_MOVE  = 6'h14;
  localparam logic [3:0]  OP_SHORT_MOVE = 4'hc;
  localparam logic [11:0] OP_LONG_MOVE  = 12'h006;
  localparam logic [9:0]  OP_BANK_LOAD  = 10'h004;
  localparam logic [7:0]  OP_LIT_ACC    = 8'h0e;
  localparam logic [6:0]  OP_ACC_STORE  = 7'h37;
  localparam logic [3:0]  OP_EXT_WORD   = 4'hf;
  localparam logic [7:0]  ACCESS_SPLIT  = 8'h60;
  localparam logic [13:0] ACCESS_HI_BASE = 14'h3f00;
  localparam logic [13:0] ACC_ADDR_DEF  = 14'h3ff0;
  localparam logic [7:0]  BSR_RST       = 8'h00;
  localparam logic [7:0]  ACC_RST       = 8'h00;

  typedef enum {S_IDLE, S_PTR2, S_SHORT2, S_LONG2, S_LONG3} dmx_state_t;

  typedef struct packed {
    logic [13:0] addr;
    logic        rd;
    logic        wr;
    logic [7:0]  wdata;
  } dmx_mem_req_t;

  typedef struct packed {
    logic neg;
    logic zero;
  } dmx_flags_t;
endpackage

`timescale 1ns/1ps
module dmx_addr_form
  import dmx_pkg::*;
(
  input  wire logic [7:0]  f_i,
  input  wire logic        a_i,
  input  wire logic [7:0]  bsr_i,
  input  wire logic        ext_en_i,
  input  wire logic [13:0] ptr2_i,
  output logic      [13:0] addr_o
);
  always_comb begin
    if (a_i) begin
      addr_o = {bsr_i[5:0], f_i};
    end else if (ext_en_i && (f_i < ACCESS_SPLIT)) begin
      addr_o = 14'(ptr2_i + {6'h00, f_i});
    end else if (f_i < ACCESS_SPLIT) begin
      addr_o = {6'h00, f_i};
    end else begin
      addr_o = ACCESS_HI_BASE | {6'h00, f_i};
    end
  end
endmodule

// ==== dmx_mem_model.sv ====
// banked data memory model facing the execution unit
`timescale 1ns/1ps
module dmx_mem_model
  import dmx_pkg::*;
(
  input  wire logic         clk_i,
  input  wire dmx_mem_req_t mem_i,
  output logic        [7:0] rdata_o
);
  logic [7:0] ram [0:16383];

  initial rdata_o = 8'h00;

  // read data good only the clock after rd; otherwise it churns so stale use shows
  always @(posedge clk_i) begin
    if (mem_i.wr === 1'b1) ram[mem_i.addr] <= mem_i.wdata;
    if (mem_i.rd === 1'b1) rdata_o <= ram[mem_i.addr];
    else rdata_o <= ~rdata_o;
  end
endmodule

// ==== tb_data_move_instruction_exec.sv ====
// self-checking bench for the data-move execution unit
`timescale 1ns/1ps
module tb_data_move_instruction_exec
  import dmx_pkg::*;
;
  logic         clk_i, srst_i, instr_valid_i, ext_en_i, instr_ack_o, busy_o;
  logic [15:0]  instr_i;
  logic [7:0]   mem_rdata_i, acc_o, bsr_o;
  dmx_mem_req_t mem_o;
  dmx_flags_t   flags_o;
  logic [41:0]  ptr_o;
  logic [1:0]   qphase_o;
  int           fail_count, compares, rd_n, wr_n;

  dmx_exec dut (.clk_i(clk_i), .srst_i(srst_i), .instr_i(instr_i),
    .instr_valid_i(instr_valid_i), .instr_ack_o(instr_ack_o), .ext_en_i(ext_en_i),
    .mem_rdata_i(mem_rdata_i), .mem_o(mem_o), .acc_o(acc_o), .bsr_o(bsr_o),
    .flags_o(flags_o), .ptr_o(ptr_o), .qphase_o(qphase_o), .busy_o(busy_o));

  dmx_mem_model u_mem (.clk_i(clk_i), .mem_i(mem_o), .rdata_o(mem_rdata_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // strobe tally, cleared by tests at the falling edge
  always @(posedge clk_i) begin
    if (mem_o.rd === 1'b1) rd_n++;
    if (mem_o.wr === 1'b1) wr_n++;
  end

  task automatic check(string nm, logic [15:0] exp, logic [15:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // word held from a falling edge until the quarter-4 edge takes it
  task automatic send(logic [15:0] w);
    int n;
    n = 0;
    @(negedge clk_i);
    instr_i = w;
    instr_valid_i = 1'b1;
    while (qphase_o !== 2'd3) begin
      @(negedge clk_i);
      n++;
      if (n > 8) begin
        fail_count++;
        print_verdict();
      end
    end
    check("instr_ack_o", 16'h1, instr_ack_o);
    @(posedge clk_i);
  endtask

  // withdraw the fetch and let the four execution clocks land
  task automatic drain();
    @(negedge clk_i);
    instr_valid_i = 1'b0;
    repeat (5) @(negedge clk_i);
  endtask

  task automatic t_reset();
    check("acc_o", 16'h0, acc_o);
    check("bsr_o", 16'h0, bsr_o);
    check("flags_o", 16'h0, flags_o);
    check("ptr_o", 16'h0, ptr_o[41:28] | ptr_o[27:14] | ptr_o[13:0]);
    check("mem strobes", 16'h0, {mem_o.rd, mem_o.wr});
    check("qphase_o", 16'h0, qphase_o);
    check("busy_o", 16'h0, busy_o);
    $display("reset test done");
  endtask

  task automatic t_literals();
    send(16'h0e5a);
    send(16'h013f);
    drain();
    check("acc_o", 16'h5a, acc_o);
    check("flags_o", 16'h0, flags_o);
    check("bsr_o", 16'h3f, bsr_o);
    send(16'h0105);
    drain();
    check("bsr_o", 16'h05, bsr_o);
    $display("literal test done");
  endtask

  task automatic t_pointer();
    send(16'hee24);
    drain();
    check("ptr2 after word 1", 16'h1000, ptr_o[41:28]);
    check("busy_o", 16'h1, busy_o);
    send(16'hf234);
    drain();
    check("ptr2", 16'h1234, ptr_o[41:28]);
    check("ptr0 ptr1", 16'h0, ptr_o[27:14] | ptr_o[13:0]);
    check("busy_o", 16'h0, busy_o);
    $display("pointer test done");
  endtask

  task automatic t_store();
    logic [15:0] w [5] = '{16'h6f80, 16'h6e10, 16'h6e80, 16'h6e5f, 16'h6e60};
    logic [13:0] a [5] = '{14'h0580, 14'h0010, 14'h3f80, 14'h1293, 14'h3f60};
    for (int i = 0; i < 5; i++) begin
      ext_en_i = (i > 2);
      send(w[i]);
      drain();
      check("stored byte", 16'h5a, u_mem.ram[a[i]]);
      check("acc_o", 16'h5a, acc_o);
    end
    ext_en_i = 1'b0;
    check("flags_o", 16'h0, flags_o);
    $display("store test done");
  endtask

  task automatic t_file_move();
    u_mem.ram[14'h0581] = 8'h80;
    u_mem.ram[14'h0582] = 8'h00;
    send(16'h5181);
    drain();
    check("acc_o", 16'h80, acc_o);
    check("flags_o", 16'h2, flags_o);
    wr_n = 0;
    send(16'h5382);
    drain();
    check("acc_o", 16'h80, acc_o);
    check("write back", 16'h1, wr_n);
    check("flags_o", 16'h1, flags_o);
    $display("file move test done");
  endtask

  task automatic t_short();
    u_mem.ram[14'h0abc] = 8'h33;
    u_mem.ram[14'h0fff] = 8'h44;
    rd_n = 0;
    wr_n = 0;
    send(16'hcabc);
    drain();
    check("busy_o", 16'h1, busy_o);
    send(16'hf123);
    drain();
    check("short dest", 16'h33, u_mem.ram[14'h0123]);
    check("short strobes", 16'h0101, {rd_n[7:0], wr_n[7:0]});
    send(16'hcfff);
    send(16'hf000);
    drain();
    check("short dest", 16'h44, u_mem.ram[14'h0000]);
    check("flags_o", 16'h1, flags_o);
    $display("short move test done");
  endtask

  task automatic lmove(logic [13:0] fs, logic [13:0] fd);
    rd_n = 0;
    wr_n = 0;
    send({12'h006, fs[13:10]});
    send({4'hf, fs[9:0], fd[13:12]});
    send({4'hf, fd[11:0]});
    drain();
  endtask

  task automatic t_long();
    u_mem.ram[14'h2000] = 8'h33;
    u_mem.ram[14'h3fff] = 8'h77;
    lmove(14'h2000, 14'h200a);
    check("long dest", 16'h33, u_mem.ram[14'h200a]);
    check("long strobes", 16'h0101, {rd_n[7:0], wr_n[7:0]});
    lmove(14'h3fff, ACC_ADDR_DEF);
    check("acc_o", 16'h77, acc_o);
    check("long strobes", 16'h0100, {rd_n[7:0], wr_n[7:0]});
    lmove(ACC_ADDR_DEF, 14'h0000);
    check("long dest", 16'h77, u_mem.ram[14'h0000]);
    check("flags_o", 16'h1, flags_o);
    $display("long move test done");
  endtask

  initial begin
    fail_count = 0;
    compares = 0;
    rd_n = 0;
    wr_n = 0;
    srst_i = 1'b1;
    instr_valid_i = 1'b0;
    instr_i = 16'h0000;
    ext_en_i = 1'b0;
    repeat (6) @(negedge clk_i);
    srst_i = 1'b0;
    t_reset();
    t_literals();
    t_pointer();
    t_store();
    t_file_move();
    t_short();
    t_long();
    print_verdict();
  end
endmodule
